// *** common/ctor_consts.svh ***
/*
  Offsets, field positions, reset values and rate figures of the
  timing override register bank.
  Assumes inclusion by the package, the design modules and the bench.
*/
`ifndef CTOR_CONSTS_SVH
`define CTOR_CONSTS_SVH

// apb geometry
`define CTOR_ADDR_W 12
`define CTOR_DATA_W 32

// register indices, byte address is four times the index
`define CTOR_IDX_CLK_PREP 8'h40
`define CTOR_IDX_CLK_ZERO 8'h41
`define CTOR_IDX_CLK_TRAIL 8'h42
`define CTOR_IDX_CLK_POST 8'h43
`define CTOR_IDX_DAT_PREP 8'h44
`define CTOR_IDX_LANE_RATE 8'h30

// field layout and number of timing parameters
`define CTOR_OV_BIT 7
`define CTOR_VAL_MSB 6
`define CTOR_NUM_PARAMS 5

// reset values of the value fields at the 800 Mbps lane rate
`define CTOR_RST_CLK_PREP 7'h05
`define CTOR_RST_CLK_ZERO 7'h1B
`define CTOR_RST_CLK_TRAIL 7'h0B
`define CTOR_RST_CLK_POST 7'h0A
`define CTOR_RST_DAT_PREP 7'h06

// lane rates in Mbps, then the 7-bit value field ceiling
`define CTOR_MBPS_400 11'h190
`define CTOR_MBPS_800 11'h320
`define CTOR_MBPS_1200 11'h4B0
`define CTOR_MBPS_1500 11'h5DC
`define CTOR_MBPS_1600 11'h640
`define CTOR_VAL_MAX 18'h0007F

`endif

// *** common/ctor_pkg.sv ***
/*
  Types and shared arithmetic of the timing override register bank.
  Assumes ctor_consts.svh on the include path.
*/
`include "ctor_consts.svh"

package ctor_pkg;

  typedef logic [6:0] ctor_time_type;

  // lane rate codes held in the lane rate register
  typedef enum logic [2:0] {
    CTOR_RATE_400 = 3'h0,
    CTOR_RATE_800 = 3'h1,
    CTOR_RATE_1200 = 3'h2,
    CTOR_RATE_1500 = 3'h3,
    CTOR_RATE_1600 = 3'h4
  } ctor_rate_type;

  // rate code to Mbps, unknown codes fall back to 800
  function automatic logic [10:0] ctor_mbps(input ctor_rate_type r);
    case (r)
      CTOR_RATE_400: ctor_mbps = `CTOR_MBPS_400;
      CTOR_RATE_1200: ctor_mbps = `CTOR_MBPS_1200;
      CTOR_RATE_1500: ctor_mbps = `CTOR_MBPS_1500;
      CTOR_RATE_1600: ctor_mbps = `CTOR_MBPS_1600;
      default: ctor_mbps = `CTOR_MBPS_800;
    endcase
  endfunction

  // byte-clock count scales with rate; rounded, saturated to 7 bits
  function automatic ctor_time_type ctor_scale(input ctor_time_type base, input ctor_rate_type r);
    logic [17:0] prod;
    logic [17:0] quo;
    prod = 18'({11'h000, base} * ctor_mbps(r)) + 18'({7'h00, `CTOR_MBPS_400});
    quo = prod / 18'({7'h00, `CTOR_MBPS_800});
    ctor_scale = (quo > `CTOR_VAL_MAX) ? 7'h7F : quo[6:0];
  endfunction

endpackage

// *** common/ctor_timing_if.sv ***
/*
  Carries the lane rate to the automatic timing calculator and the
  derived timing values back to the register bank.
  Assumes both ends run on the same pclk.
*/
`timescale 1ns/1ps

interface ctor_timing_if;
  ctor_pkg::ctor_rate_type rate;
  ctor_pkg::ctor_time_type auto_val [0:4];
  modport src (input rate, output auto_val);
  modport dst (output rate, input auto_val);
endinterface

// *** design/ctor_auto_timing.sv ***
/*
  Automatic timing calculator: derives the five transition timings
  from the selected lane rate.
  Assumes pclk domain, asynchronous active-low reset.
*/
`timescale 1ns/1ps
`include "ctor_consts.svh"

module ctor_auto_timing (
  input wire logic pclk,
  input wire logic presetn,
  ctor_timing_if.src tif
);

  // registered derivation, reset to the 800 Mbps figures
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tif.auto_val[0] <= `CTOR_RST_CLK_PREP;
      tif.auto_val[1] <= `CTOR_RST_CLK_ZERO;
      tif.auto_val[2] <= `CTOR_RST_CLK_TRAIL;
      tif.auto_val[3] <= `CTOR_RST_CLK_POST;
      tif.auto_val[4] <= `CTOR_RST_DAT_PREP;
    end else begin
      tif.auto_val[0] <= ctor_pkg::ctor_scale(`CTOR_RST_CLK_PREP, tif.rate);
      tif.auto_val[1] <= ctor_pkg::ctor_scale(`CTOR_RST_CLK_ZERO, tif.rate);
      tif.auto_val[2] <= ctor_pkg::ctor_scale(`CTOR_RST_CLK_TRAIL, tif.rate);
      tif.auto_val[3] <= ctor_pkg::ctor_scale(`CTOR_RST_CLK_POST, tif.rate);
      tif.auto_val[4] <= ctor_pkg::ctor_scale(`CTOR_RST_DAT_PREP, tif.rate);
    end
  end

endmodule // ctor_auto_timing

// *** design/ctor_regs.sv ***
/*
  APB register bank for the five link transition timings of the
  serial camera output: clock prepare, zero, trail, post and data
  prepare, each with an override bit, plus a lane rate register.
  Assumes an APB master on pclk and a single asynchronous reset.

*/
`timescale 1ns/1ps
`include "ctor_consts.svh"

module ctor_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [6:0] clock_prepare_time,
  output logic [6:0] clock_zero_time,
  output logic [6:0] clock_trail_time,
  output logic [6:0] clock_post_time,
  output logic [6:0] data_prepare_time,
  output logic [2:0] lane_rate
);

  // override bits, stored values and applied timings per parameter
  logic ov_reg [0:4];
  ctor_pkg::ctor_time_type val_reg [0:4];
  ctor_pkg::ctor_time_type eff_reg [0:4];
  ctor_pkg::ctor_rate_type rate_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_next;
  logic [7:0] idx;
  logic aligned;
  logic param_hit;
  logic rate_hit;
  logic map_hit;
  logic [2:0] sel;
  logic wr_take;
  logic rd_setup;

  ctor_timing_if tif();

  // automatic timing derivation from the lane rate
  ctor_auto_timing u_auto (
    .pclk(pclk),
    .presetn(presetn),
    .tif(tif)
  );

  assign tif.rate = rate_reg;

  // word index of a byte address, zero when out of range
  function automatic logic [7:0] addr_index(input logic [11:0] a);
    addr_index = (a[11:10] == 2'h0) ? a[9:2] : 8'h00;
  endfunction

  // parameter number of a timing register index
  function automatic logic [2:0] param_of(input logic [7:0] i);
    param_of = 3'(i - `CTOR_IDX_CLK_PREP);
  endfunction

  // index falls on one of the five timing registers
  function automatic logic is_param(input logic [7:0] i);
    is_param = (i >= `CTOR_IDX_CLK_PREP) && (i <= `CTOR_IDX_DAT_PREP);
  endfunction

  // reset value of a parameter's value field
  function automatic ctor_pkg::ctor_time_type rst_val(input int i);
    case (i)
      0: rst_val = `CTOR_RST_CLK_PREP;
      1: rst_val = `CTOR_RST_CLK_ZERO;
      2: rst_val = `CTOR_RST_CLK_TRAIL;
      3: rst_val = `CTOR_RST_CLK_POST;
      default: rst_val = `CTOR_RST_DAT_PREP;
    endcase
  endfunction

  // address decode, only whole aligned words are mapped
  assign idx = addr_index(paddr);
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign param_hit = aligned && is_param(idx);
  assign rate_hit = aligned && (idx == `CTOR_IDX_LANE_RATE);
  assign map_hit = param_hit || rate_hit;
  assign sel = param_of(idx);

  // write takes effect only in the access phase, low byte enabled
  assign wr_take = psel && penable && pwrite && pstrb[0] && map_hit;
  assign rd_setup = psel && !penable && !pwrite;

  // zero wait state slave, error on unmapped words
  assign pready = 1'b1;
  assign pslverr = psel && penable && !map_hit;

  // override bits and stored values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `CTOR_NUM_PARAMS; i++) begin
        ov_reg[i] <= 1'b0;
        val_reg[i] <= rst_val(i);
      end
    end else if (wr_take && param_hit) begin
      for (int i = 0; i < `CTOR_NUM_PARAMS; i++) begin
        if (sel == 3'(i)) begin
          ov_reg[i] <= pwdata[`CTOR_OV_BIT];
          // value only lands when the write leaves override set
          if (pwdata[`CTOR_OV_BIT]) begin
            val_reg[i] <= pwdata[`CTOR_VAL_MSB:0];
          end // else ignored
        end
      end
    end
  end

  // lane rate register, undefined codes are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_reg <= ctor_pkg::CTOR_RATE_800;
    end else if (wr_take && rate_hit && (pwdata[2:0] <= 3'h4)) begin
      rate_reg <= ctor_pkg::ctor_rate_type'(pwdata[2:0]);
    end
  end

  // applied timings: stored value under override, else derived
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `CTOR_NUM_PARAMS; i++) begin
        eff_reg[i] <= rst_val(i);
      end
    end else begin
      for (int i = 0; i < `CTOR_NUM_PARAMS; i++) begin
        eff_reg[i] <= ov_reg[i] ? val_reg[i] : tif.auto_val[i];
      end
    end
  end

  // read mux, field shows derived value while override is clear
  always_comb begin
    rd_next = 32'h00000000;
    if (param_hit) begin
      for (int i = 0; i < `CTOR_NUM_PARAMS; i++) begin
        if (sel == 3'(i)) begin
          rd_next[`CTOR_OV_BIT] = ov_reg[i];
          rd_next[`CTOR_VAL_MSB:0] = ov_reg[i] ? val_reg[i] : tif.auto_val[i];
        end
      end
    end else if (rate_hit) begin
      rd_next[2:0] = rate_reg;
    end
  end

  // read data captured in the setup phase, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_reg <= rd_next;
    end
  end

  // port drive
  assign prdata = prdata_reg;
  assign clock_prepare_time = eff_reg[0];
  assign clock_zero_time = eff_reg[1];
  assign clock_trail_time = eff_reg[2];
  assign clock_post_time = eff_reg[3];
  assign data_prepare_time = eff_reg[4];
  assign lane_rate = rate_reg;

  // checks of the bank's own behaviour
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  clk_prep_sel_a: assert property (
    ##1 clock_prepare_time == $past(ov_reg[0] ? val_reg[0] : tif.auto_val[0]))
    else $error("clock prepare source wrong");

  clk_zero_sel_a: assert property (
    ##1 clock_zero_time == $past(ov_reg[1] ? val_reg[1] : tif.auto_val[1]))
    else $error("clock zero source wrong");

  clk_trail_sel_a: assert property (
    ##1 clock_trail_time == $past(ov_reg[2] ? val_reg[2] : tif.auto_val[2]))
    else $error("clock trail source wrong");

  clk_post_sel_a: assert property (
    ##1 clock_post_time == $past(ov_reg[3] ? val_reg[3] : tif.auto_val[3]))
    else $error("clock post source wrong");

  dat_prep_sel_a: assert property (
    ##1 data_prepare_time == $past(ov_reg[4] ? val_reg[4] : tif.auto_val[4]))
    else $error("data prepare source wrong");

  ro_write_drop_a: assert property (
    (wr_take && param_hit && sel == 3'h1 && !pwdata[7])
    |=> (val_reg[1] == $past(val_reg[1])) && !ov_reg[1])
    else $error("value written while override clear");

  ro_read_auto_a: assert property (
    (rd_setup && param_hit && sel == 3'h0 && !ov_reg[0])
    |=> prdata[6:0] == $past(tif.auto_val[0]) && !prdata[7])
    else $error("read does not show derived value");

  rw_store_apply_a: assert property (
    (wr_take && param_hit && sel == 3'h2 && pwdata[7])
    |=> (val_reg[2] == $past(pwdata[6:0])) ##1 (clock_trail_time == $past(val_reg[2])))
    else $error("override value not stored or applied");

  default_800_a: assert property (
    (rate_reg == ctor_pkg::CTOR_RATE_800) [*2]
    |-> tif.auto_val[0] == 7'h05 && tif.auto_val[1] == 7'h1B && tif.auto_val[2] == 7'h0B
        && tif.auto_val[3] == 7'h0A && tif.auto_val[4] == 7'h06)
    else $error("derived defaults differ from 800 Mbps set");

  rate_recompute_a: assert property (
    $changed(rate_reg)
    |=> tif.auto_val[1] == ctor_pkg::ctor_scale(7'h1B, rate_reg)
        && tif.auto_val[4] == ctor_pkg::ctor_scale(7'h06, rate_reg))
    else $error("derived timing not recomputed for new rate");

  ov_release_a: assert property (
    $fell(ov_reg[3]) |=> clock_post_time == $past(tif.auto_val[3]))
    else $error("override release not immediate");

  unmapped_err_a: assert property (
    (psel && penable && !map_hit) |-> pslverr && pready)
    else $error("unmapped access without error");

endmodule // ctor_regs

// *** verif/ctor_csi_rx_model.sv ***
/*
  Behavioural model of the downstream serial camera receiver that
  consumes the five applied transition timings.
  Assumes the timings come from the register bank on the same pclk.
*/
`timescale 1ns/1ps

module ctor_csi_rx_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [6:0] clock_prepare_time,
  input wire logic [6:0] clock_zero_time,
  input wire logic [6:0] clock_trail_time,
  input wire logic [6:0] clock_post_time,
  input wire logic [6:0] data_prepare_time,
  output logic [34:0] seen_timing
);
  // latch the timings the receiver would apply, prepare in the low slice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_timing <= 35'h0;
    end else begin
      seen_timing <= {data_prepare_time, clock_post_time, clock_trail_time, clock_zero_time, clock_prepare_time};
    end
  end
endmodule // ctor_csi_rx_model

// *** verif/tb_csi_phy_timing_override_regs.sv ***
/*
  Self-checking bench for the timing override register bank.
  Assumes ctor_consts.svh on the include path and an APB slave
  that answers by pready in its own time.
*/
`timescale 1ns/1ps
`include "ctor_consts.svh"

module tb_csi_phy_timing_override_regs;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] tim [0:4];
  logic [2:0] lane_rate;
  logic [34:0] seen_timing;
  logic [31:0] rdat;
  logic rerr;
  int miscompares = 0;
  int n_compared = 0;
  logic [7:0] idx_tab [0:4] = '{`CTOR_IDX_CLK_PREP, `CTOR_IDX_CLK_ZERO, `CTOR_IDX_CLK_TRAIL,
                                `CTOR_IDX_CLK_POST, `CTOR_IDX_DAT_PREP};
  logic [6:0] rst_tab [0:4] = '{7'h05, 7'h1B, 7'h0B, 7'h0A, 7'h06};
  logic [6:0] ov_tab [0:4] = '{7'h7F, 7'h00, 7'h55, 7'h2A, 7'h01};
  int mbps_tab [0:4] = '{400, 800, 1200, 1500, 1600};
  logic [11:0] rate_addr = 12'({`CTOR_IDX_LANE_RATE, 2'b00});

  // 50 MHz clock
  always #10 pclk = ~pclk;

  ctor_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(3'h0), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clock_prepare_time(tim[0]), .clock_zero_time(tim[1]), .clock_trail_time(tim[2]),
    .clock_post_time(tim[3]), .data_prepare_time(tim[4]), .lane_rate(lane_rate));

  ctor_csi_rx_model rx_u (.pclk(pclk), .presetn(presetn), .clock_prepare_time(tim[0]),
    .clock_zero_time(tim[1]), .clock_trail_time(tim[2]), .clock_post_time(tim[3]),
    .data_prepare_time(tim[4]), .seen_timing(seen_timing));

  // derived value: rounded scaling of the 800 Mbps default, saturated
  function automatic logic [6:0] derive(input logic [6:0] base, input int mbps);
    int q;
    q = (int'(base) * mbps + 400) / 800;
    return (q > 127) ? 7'h7F : 7'(q);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  // one apb transfer: setup, then access until pready
  task automatic acc(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int i, input logic [31:0] d);
    acc(12'({idx_tab[i], 2'b00}), 1'b1, d, 4'hF);
  endtask

  task automatic rd_chk(input int i, input logic [7:0] exp);
    acc(12'({idx_tab[i], 2'b00}), 1'b0, 32'h0, 4'hF);
    check(rdat, {24'h0, exp});
  endtask

  // compare one receiver timing slice, callers settle the register, derivation and receiver stages first
  task automatic out_chk(input int i, input logic [6:0] exp);
    check({25'h0, seen_timing[i*7 +: 7]}, {25'h0, exp});
  endtask

  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset values are the 800 Mbps derived timings
    for (int i = 0; i < 5; i++) rd_chk(i, {1'b0, rst_tab[i]});
    acc(rate_addr, 1'b0, 32'h0, 4'hF);
    check(rdat, 32'h1);
    settle();
    for (int i = 0; i < 5; i++) out_chk(i, rst_tab[i]);
    // value writes without override are ignored
    for (int i = 0; i < 5; i++) wr(i, 32'h7F);
    for (int i = 0; i < 5; i++) rd_chk(i, {1'b0, rst_tab[i]});
    // override with boundary values, applied to the outputs
    for (int i = 0; i < 5; i++) wr(i, {24'h0, 1'b1, ov_tab[i]});
    settle();
    for (int i = 0; i < 5; i++) rd_chk(i, {1'b1, ov_tab[i]});
    for (int i = 0; i < 5; i++) out_chk(i, ov_tab[i]);
    // a rate change leaves overridden values alone
    acc(rate_addr, 1'b1, 32'h4, 4'hF);
    settle();
    for (int i = 0; i < 5; i++) rd_chk(i, {1'b1, ov_tab[i]});
    for (int i = 0; i < 5; i++) out_chk(i, ov_tab[i]);
    // clearing override falls back to the derived value once settled
    for (int i = 0; i < 5; i++) wr(i, 32'h0);
    settle();
    for (int i = 0; i < 5; i++) rd_chk(i, {1'b0, derive(rst_tab[i], 1600)});
    for (int i = 0; i < 5; i++) out_chk(i, derive(rst_tab[i], 1600));
    // every defined lane rate code, 0 to 4, recomputes the derived fields
    for (int r = 0; r < 5; r++) begin
      acc(rate_addr, 1'b1, 32'(r), 4'hF);
      settle();
      check({29'h0, lane_rate}, 32'(r));
      for (int i = 0; i < 5; i++) rd_chk(i, {1'b0, derive(rst_tab[i], mbps_tab[r])});
      for (int i = 0; i < 5; i++) out_chk(i, derive(rst_tab[i], mbps_tab[r]));
    end
    // an undefined rate code is ignored
    acc(rate_addr, 1'b1, 32'h5, 4'hF);
    acc(rate_addr, 1'b0, 32'h0, 4'hF);
    check(rdat, 32'h4);
    // an unaligned access answers with an error and writes nothing
    acc(12'h101, 1'b1, 32'h85, 4'hF);
    check({31'h0, rerr}, 32'h1);
    // a write with the low byte strobe off changes nothing
    acc(12'({idx_tab[0], 2'b00}), 1'b1, 32'h85, 4'hE);
    rd_chk(0, {1'b0, derive(rst_tab[0], 1600)});
    // an unmapped word answers with an error and reads zero
    acc(12'h1FC, 1'b0, 32'h0, 4'hF);
    check({rdat[31:1], rerr}, 32'h1);
    finish_test();
  end

  // watchdog far beyond the expected run length
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
endmodule // tb_csi_phy_timing_override_regs
